// File: design/touch_setup_device.sv
// Device end: interprets setup command bytes and holds per-key and global setup.
// Assumes the host end on the link and a sensing core on the user-side ports.
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns

// Functional notes
// - Positive recal delay per key, rounded down
// - Zero positive delay: no positive recal
// - Negative recal delay 0x0C, echoed on Put
// - Zero negative delay: no prolonged-touch recal
// - Pulse spacing global, 2 to 10 only
// - Get returns stored pulse spacing
// - Positive band global, clipped to 100
// - Flag key whose reference exceeds positive band
// - Band flags only after key recalibrated
// - Host recalibrates keys with extreme references; no recal command here, only flagged on key_error_o, pos_band_err_o and neg_band_err_o
// - Zero positive band disables positive check
// - Negative band global, clipped to 99
// - Zero negative band disables negative check
// - Suppression enable per key, default off
// - Suppression only among enabled, bursting keys
// - Supervisory commands ignore key scope
// - Host returns to Get mode after Put
// - DAC test: Put only, value within timeout
// - DAC test stops sensing until reset
// - DAC test zeroes all burst lengths first
// - Lock reference: null second byte, echo
// - Lock needs Put, no gap, timeout
// - Zero burst key reports error
module touch_setup_device
	import touch_setup_pkg::*;
#(
	parameter int NUM_KEYS    = KEY_COUNT,
	parameter int REF_W       = 16,
	parameter int ARG_TIMEOUT = ARG_TIMEOUT_CYCLES
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_i,
	touch_link_if.device          link,
	input  wire logic [KEY_W-1:0] query_key_i,
	input  wire logic [REF_W-1:0] ref_level_i,
	input  wire logic [REF_W-1:0] locked_ref_i,
	input  wire logic             key_recalibrated_i,
	output logic      [7:0]       pos_delay_o,
	output logic      [7:0]       neg_delay_o,
	output logic                  pos_recal_en_o,
	output logic                  neg_recal_en_o,
	output logic                  adj_part_o,
	output logic                  key_error_o,
	output logic                  pos_band_err_o,
	output logic                  neg_band_err_o,
	output logic      [7:0]       pulse_spacing_o,
	output logic      [7:0]       pos_band_o,
	output logic      [7:0]       neg_band_o,
	output logic                  sensing_en_o,
	output logic      [7:0]       dac_value_o,
	output logic                  dac_load_o,
	output logic                  lock_ref_o
);

	localparam int TMR_W = $clog2(ARG_TIMEOUT + 1);
	localparam int PW    = REF_W + 8;

	typedef enum logic {ST_IDLE, ST_ARG} state_t;

	state_t              state_q;
	logic   [7:0]        opcode_q;
	logic   [TMR_W-1:0]  timer_q;
	logic   [7:0]        pos_dly_q [NUM_KEYS];
	logic   [7:0]        neg_dly_q [NUM_KEYS];
	logic   [NUM_KEYS-1:0] adj_en_q;
	logic   [NUM_KEYS-1:0] burst_on_q;
	logic   [7:0]        pulse_q;
	logic   [7:0]        pband_q;
	logic   [7:0]        nband_q;
	logic                dac_mode_q;
	logic   [7:0]        dac_q;
	logic                dac_load_q;
	logic                lock_q;
	logic   [7:0]        rsp_byte_q;
	logic                rsp_valid_q;
	logic                pos_err_q;
	logic                neg_err_q;
	logic                key_err_q;

	// Command byte classification
	wire [7:0] rx       = link.cmd_byte;
	wire       is_key   = (rx == CMD_POS_RECAL) | (rx == CMD_NEG_RECAL) | (rx == CMD_ADJ_SUPP);
	wire       is_glob  = (rx == CMD_PULSE_SP) | (rx == CMD_POS_BAND) | (rx == CMD_NEG_BAND);
	wire       is_super = (rx == CMD_DAC_TEST) | (rx == CMD_LOCK_REF);
	wire       start    = (state_q == ST_IDLE) & link.cmd_valid & link.put_mode
	                      & (is_key | is_glob | is_super);
	wire       get_cmd  = (state_q == ST_IDLE) & link.cmd_valid & ~link.put_mode
	                      & (is_key | is_glob);
	wire       timeout  = (state_q == ST_ARG) & (timer_q == TMR_W'(ARG_TIMEOUT - 1));
	// Argument accepted only while still in Put mode; any byte ends the wait
	wire       arg_take = (state_q == ST_ARG) & link.cmd_valid & link.put_mode;

	// Write strobes per command
	wire wr_pos   = arg_take & (opcode_q == CMD_POS_RECAL);
	wire wr_neg   = arg_take & (opcode_q == CMD_NEG_RECAL);
	wire wr_adj   = arg_take & (opcode_q == CMD_ADJ_SUPP) & (rx <= 8'h01);
	wire wr_pulse = arg_take & (opcode_q == CMD_PULSE_SP)
	                & (rx >= PULSE_MIN) & (rx <= PULSE_MAX);
	wire wr_pband = arg_take & (opcode_q == CMD_POS_BAND);
	wire wr_nband = arg_take & (opcode_q == CMD_NEG_BAND);
	wire wr_dac   = arg_take & (opcode_q == CMD_DAC_TEST);
	wire wr_lock  = arg_take & (opcode_q == CMD_LOCK_REF) & (rx == NULL_BYTE);
	wire echo     = arg_take & ~((opcode_q == CMD_LOCK_REF) & (rx != NULL_BYTE));

	// Scope decode: one key, a row of eight, a column of eight, or all keys
	wire [KEY_W-1:0] skey = link.scope_key;
	wire [NUM_KEYS-1:0] in_scope;
	genvar g;
	generate
		for (g = 0; g < NUM_KEYS; g++) begin : g_scope
			localparam logic [KEY_W-1:0] KI = KEY_W'(g);
			assign in_scope[g] =
				(scope_t'(link.scope_sel) == SCOPE_ALL) |
				((scope_t'(link.scope_sel) == SCOPE_KEY) & (KI == skey)) |
				((scope_t'(link.scope_sel) == SCOPE_ROW) &
				 (KI[KEY_W-1:ROW_LSB] == skey[KEY_W-1:ROW_LSB])) |
				((scope_t'(link.scope_sel) == SCOPE_COL) &
				 (KI[ROW_LSB-1:0] == skey[ROW_LSB-1:0]));
		end
	endgenerate

	// Get replies read the key named by the scope
	wire [7:0] get_val =
		(rx == CMD_POS_RECAL) ? pos_dly_q[skey] :
		(rx == CMD_NEG_RECAL) ? neg_dly_q[skey] :
		(rx == CMD_ADJ_SUPP)  ? {7'h00, adj_en_q[skey]} :
		(rx == CMD_PULSE_SP)  ? pulse_q :
		(rx == CMD_POS_BAND)  ? pband_q : nband_q;

	// Argument wait: opens on a known Put command, closes on a byte or timeout
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_q  <= ST_IDLE;
			opcode_q <= 8'h00;
			timer_q  <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					timer_q <= '0;
					if (start) begin
						state_q  <= ST_ARG;
						opcode_q <= rx;
					end
				end
				ST_ARG: begin
					timer_q <= timer_q + TMR_W'(1);
					if (link.cmd_valid | timeout) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Per-key setup, written only for keys in scope
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			for (int k = 0; k < NUM_KEYS; k++) begin
				pos_dly_q[k] <= DELAY_RST;
				neg_dly_q[k] <= DELAY_RST;
			end
			adj_en_q <= '0;
		end else begin
			for (int k = 0; k < NUM_KEYS; k++) begin
				if (in_scope[k] & wr_pos) begin
					pos_dly_q[k] <= round_delay(rx);
				end
				if (in_scope[k] & wr_neg) begin
					neg_dly_q[k] <= round_delay(rx);
				end
				if (in_scope[k] & wr_adj) begin
					adj_en_q[k] <= rx[0];
				end
			end
		end
	end

	// Global setup, one shared value each, scope ignored
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pulse_q <= PULSE_RST;
			pband_q <= BAND_RST;
			nband_q <= BAND_RST;
		end else begin
			if (wr_pulse) pulse_q <= rx;
			if (wr_pband) pband_q <= (rx > POS_BAND_MAX) ? POS_BAND_MAX : rx;
			if (wr_nband) nband_q <= (rx > NEG_BAND_MAX) ? NEG_BAND_MAX : rx;
		end
	end

	// DAC test and lock reference; DAC mode holds until reset
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			dac_mode_q <= 1'b0;
			dac_q      <= DAC_RST;
			dac_load_q <= 1'b0;
			lock_q     <= 1'b0;
			burst_on_q <= '1;
		end else begin
			dac_load_q <= wr_dac;
			lock_q     <= wr_lock;
			if (wr_dac) begin
				dac_mode_q <= 1'b1;
				dac_q      <= rx;
				burst_on_q <= '0;
			end
		end
	end

	// Replies: echo after an accepted Put, value after a Get
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rsp_valid_q <= 1'b0;
			rsp_byte_q  <= 8'h00;
		end else begin
			rsp_valid_q <= echo | get_cmd;
			if (echo) begin
				rsp_byte_q <= opcode_q;
			end else if (get_cmd) begin
				rsp_byte_q <= get_val;
			end
		end
	end

	// Reference boundary checks for the queried key
	wire [PW-1:0] ref_w     = PW'(ref_level_i);
	wire [PW-1:0] lock_w    = PW'(locked_ref_i);
	wire [PW-1:0] pos_lhs   = PW'(ref_w * PW'(10));
	wire [PW-1:0] pos_rhs   = PW'(lock_w * (PW'(10) + PW'(pband_q)));
	wire [PW-1:0] neg_lhs   = PW'(ref_w * PW'(100));
	wire [PW-1:0] neg_rhs   = PW'(lock_w * PW'(nband_q));
	wire          pos_check = (pband_q != 8'h00) & key_recalibrated_i;
	wire          neg_check = (nband_q != 8'h00) & key_recalibrated_i;
	wire          pos_err_d = pos_check & (pos_lhs > pos_rhs);
	wire          neg_err_d = neg_check & (neg_lhs < neg_rhs);

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pos_err_q <= 1'b0;
			neg_err_q <= 1'b0;
			key_err_q <= 1'b0;
		end else begin
			pos_err_q <= pos_err_d;
			neg_err_q <= neg_err_d;
			key_err_q <= ~burst_on_q[query_key_i] | pos_err_d | neg_err_d;
		end
	end

	// Per-key and global view for the sensing core, and the reply to the link
	assign pos_delay_o     = pos_dly_q[query_key_i];
	assign neg_delay_o     = neg_dly_q[query_key_i];
	assign pos_recal_en_o  = (pos_dly_q[query_key_i] != DELAY_RST);
	assign neg_recal_en_o  = (neg_dly_q[query_key_i] != DELAY_RST);
	assign adj_part_o      = adj_en_q[query_key_i] & burst_on_q[query_key_i];
	assign key_error_o     = key_err_q;
	assign pos_band_err_o  = pos_err_q;
	assign neg_band_err_o  = neg_err_q;
	assign pulse_spacing_o = pulse_q;
	assign pos_band_o      = pband_q;
	assign neg_band_o      = nband_q;
	assign sensing_en_o    = ~dac_mode_q;
	assign dac_value_o     = dac_q;
	assign dac_load_o      = dac_load_q;
	assign lock_ref_o      = lock_q;
	assign link.rsp_byte   = rsp_byte_q;
	assign link.rsp_valid  = rsp_valid_q;

endmodule

// File: common/touch_setup_pkg.sv
// Shared constants for the touch setup command handler and its host end.
// Assumes a 100 MHz system clock and a byte-wide command link.
package touch_setup_pkg;

	// Key array
	localparam int KEY_COUNT = 64;
	localparam int KEY_W     = 6;
	localparam int ROW_LSB   = 3;

	// Command codes
	localparam logic [7:0] CMD_POS_RECAL = 8'h0b;
	localparam logic [7:0] CMD_NEG_RECAL = 8'h0c;
	localparam logic [7:0] CMD_PULSE_SP  = 8'h0d;
	localparam logic [7:0] CMD_POS_BAND  = 8'h0e;
	localparam logic [7:0] CMD_NEG_BAND  = 8'h0f;
	localparam logic [7:0] CMD_ADJ_SUPP  = 8'h10;
	localparam logic [7:0] CMD_DAC_TEST  = 8'h44;
	localparam logic [7:0] CMD_LOCK_REF  = 8'h4c;
	localparam logic [7:0] NULL_BYTE     = 8'h00;

	// Argument limits
	localparam logic [7:0] PULSE_MIN    = 8'h02;
	localparam logic [7:0] PULSE_MAX    = 8'h0a;
	localparam logic [7:0] POS_BAND_MAX = 8'h64;
	localparam logic [7:0] NEG_BAND_MAX = 8'h63;

	// Reset values
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [7:0] PULSE_RST = 8'h02;
	localparam logic [7:0] BAND_RST  = 8'h00;
	localparam logic [7:0] DAC_RST   = 8'h00;

	// Delay units seen by the sensing core
	localparam int POS_DELAY_UNIT_MS = 100;
	localparam int NEG_DELAY_UNIT_MS = 1000;

	// Argument byte timeout
	localparam int CLK_KHZ            = 100000;
	localparam int ARG_TIMEOUT_MS     = 100;
	localparam int ARG_TIMEOUT_CYCLES = ARG_TIMEOUT_MS * CLK_KHZ;

	// Scope selection
	typedef enum logic [1:0] {SCOPE_KEY, SCOPE_ROW, SCOPE_COL, SCOPE_ALL} scope_t;

	// Host register map (byte offsets) and fields
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_TX     = 8'h04;
	localparam logic [7:0] REG_RX     = 8'h08;
	localparam int CTRL_PUT_BIT       = 0;
	localparam int CTRL_SCOPE_LSB     = 1;
	localparam int CTRL_AUTO_GET_BIT  = 3;
	localparam int CTRL_KEY_LSB       = 8;
	localparam int RX_NEW_BIT         = 8;

	// Valid delay settings, ascending
	localparam logic [7:0] DELAY_SET [16] = '{
		8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0a, 8'h0f,
		8'h14, 8'h20, 8'h2d, 8'h3c, 8'h5a, 8'h7b, 8'haf, 8'hff};

	// Largest valid delay not above the request
	function automatic logic [7:0] round_delay(input logic [7:0] v);
		logic [7:0] r;
		r = DELAY_SET[0];
		for (int i = 0; i < 16; i++) begin
			if (DELAY_SET[i] <= v) begin
				r = DELAY_SET[i];
			end
		end
		return r;
	endfunction

endpackage

// File: common/touch_link_if.sv
// Byte link between the host controller and the touch setup handler.
// Both ends run on the same system clock; strobes are one-cycle pulses.
`timescale 1ns/1ns
interface touch_link_if;
	logic [7:0] cmd_byte;
	logic       cmd_valid;
	logic       put_mode;
	logic [1:0] scope_sel;
	logic [5:0] scope_key;
	logic [7:0] rsp_byte;
	logic       rsp_valid;

	modport host (
		output cmd_byte, cmd_valid, put_mode, scope_sel, scope_key,
		input  rsp_byte, rsp_valid
	);
	modport device (
		input  cmd_byte, cmd_valid, put_mode, scope_sel, scope_key,
		output rsp_byte, rsp_valid
	);
endinterface

// File: design/touch_setup_host.sv
// Host end: AHB-Lite register slave that drives command bytes onto the link.
// Assumes one AHB-Lite master doing single word transfers, zero wait states.
`timescale 1ns/1ns
module touch_setup_host
	import touch_setup_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic      [31:0] hrdata_o,
	touch_link_if.host       link
);

	logic        dph_q;
	logic        dwr_q;
	logic [7:0]  daddr_q;
	logic [31:0] hrdata_q;
	logic        put_q;
	logic [1:0]  scope_q;
	logic [5:0]  key_q;
	logic        auto_get_q;
	logic [7:0]  tx_q;
	logic        tx_valid_q;
	logic [7:0]  rx_q;
	logic        rx_new_q;

	// Address and data phase decode
	wire [7:0] off     = haddr_i[7:0];
	wire       aph     = hsel_i & htrans_i[1] & hready_i;
	wire       rd_rx   = aph & ~hwrite_i & (off == REG_RX);
	wire       wr_ctrl = dph_q & dwr_q & (daddr_q == REG_CTRL);
	wire       wr_tx   = dph_q & dwr_q & (daddr_q == REG_TX);
	wire [31:0] ctrl_v = {18'h00000, key_q, 4'h0, auto_get_q, scope_q, put_q};
	wire [31:0] rd_v   = (off == REG_CTRL) ? ctrl_v :
	                     (off == REG_RX)   ? {23'h000000, rx_new_q, rx_q} : 32'h00000000;
	// Auto return to Get once the device answers a Put exchange
	wire       auto_clr = auto_get_q & put_q & link.rsp_valid;

	// Bus phase tracking and read data
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			dph_q    <= 1'b0;
			dwr_q    <= 1'b0;
			daddr_q  <= 8'h00;
			hrdata_q <= 32'h00000000;
		end else begin
			dph_q <= aph;
			if (aph) begin
				dwr_q   <= hwrite_i;
				daddr_q <= off;
			end
			if (aph & ~hwrite_i) begin
				hrdata_q <= rd_v;
			end
		end
	end

	// Control register: mode, scope and auto return to Get
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			put_q      <= 1'b0;
			scope_q    <= 2'h0;
			key_q      <= 6'h00;
			auto_get_q <= 1'b0;
		end else if (wr_ctrl) begin
			put_q      <= hwdata_i[CTRL_PUT_BIT];
			scope_q    <= hwdata_i[CTRL_SCOPE_LSB +: 2];
			key_q      <= hwdata_i[CTRL_KEY_LSB +: 6];
			auto_get_q <= hwdata_i[CTRL_AUTO_GET_BIT];
		end else if (auto_clr) begin
			put_q <= 1'b0;
		end
	end

	// Transmit one byte per TX write; software paces the second byte
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_q       <= 8'h00;
			tx_valid_q <= 1'b0;
		end else begin
			tx_valid_q <= wr_tx;
			if (wr_tx) begin
				tx_q <= hwdata_i[7:0];
			end
		end
	end

	// Reply capture; a new reply wins over a read clear in the same cycle
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rx_q     <= 8'h00;
			rx_new_q <= 1'b0;
		end else begin
			rx_new_q <= link.rsp_valid | (rx_new_q & ~rd_rx);
			if (link.rsp_valid) begin
				rx_q <= link.rsp_byte;
			end
		end
	end

	assign hreadyout_o    = 1'b1;
	assign hresp_o        = 1'b0;
	assign hrdata_o       = hrdata_q;
	assign link.cmd_byte  = tx_q;
	assign link.cmd_valid = tx_valid_q;
	assign link.put_mode  = put_q;
	assign link.scope_sel = scope_q;
	assign link.scope_key = key_q;

endmodule

// File: tb/touch_link_chk.sv
// Checker for the byte link between the host and device ends.
// Assumes one system clock and the argument timeout of the device end.
`timescale 1ns/1ns
module touch_link_chk
	import touch_setup_pkg::*;
#(
	parameter int ARG_TIMEOUT = ARG_TIMEOUT_CYCLES
) (
	input wire logic       clk_sys_i,
	input wire logic       reset_i,
	input wire logic [7:0] cmd_byte,
	input wire logic       cmd_valid,
	input wire logic       put_mode,
	input wire logic [1:0] scope_sel,
	input wire logic [5:0] scope_key,
	input wire logic [7:0] rsp_byte,
	input wire logic       rsp_valid
);
	logic       pend_q;
	logic       pend_d;
	logic [7:0] code_q;
	logic [7:0] code_d;
	int         cnt_q;
	int         cnt_d;
	logic       two_byte;
	logic       arg;
	logic       get_cmd;

	// Codes that wait for an argument, and bytes taken as arguments
	assign two_byte = (cmd_byte >= CMD_POS_RECAL && cmd_byte <= CMD_ADJ_SUPP)
		|| cmd_byte == CMD_DAC_TEST || cmd_byte == CMD_LOCK_REF;
	// The wait closes on the last counted cycle, as the device end does
	assign arg = cmd_valid && pend_q && cnt_q < ARG_TIMEOUT;
	assign get_cmd = cmd_valid && !pend_q && !put_mode;
	assign pend_d = pend_q ? !(cmd_valid || cnt_q >= ARG_TIMEOUT - 1)
		: (cmd_valid && put_mode && two_byte);
	assign code_d = (cmd_valid && !pend_q) ? cmd_byte : code_q;
	assign cnt_d = pend_q ? cnt_q + 1 : 0;

	// Track the code awaiting its argument
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pend_q <= 1'b0;
			code_q <= 8'h00;
			cnt_q <= 0;
		end else begin
			pend_q <= pend_d;
			code_q <= code_d;
			cnt_q <= cnt_d;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	rsp_has_cause_a: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("reply without a byte one cycle before");
	rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_byte))
		else $error("reply byte changed without a reply");
	put_echo_a: assert property (arg && put_mode && code_q != CMD_LOCK_REF
		|=> rsp_valid && rsp_byte == code_q) else $error("argument not echoed");
	lock_echo_a: assert property (arg && put_mode && code_q == CMD_LOCK_REF
		&& cmd_byte == NULL_BYTE |=> rsp_valid && rsp_byte == CMD_LOCK_REF)
		else $error("lock not echoed");
	lock_fail_a: assert property (arg && code_q == CMD_LOCK_REF
		&& cmd_byte != NULL_BYTE |=> !rsp_valid [*2]) else $error("bad lock echoed");
	get_arg_a: assert property (arg && !put_mode |=> !rsp_valid)
		else $error("argument echoed in get mode");
	get_silent_a: assert property (get_cmd
		&& (cmd_byte == CMD_DAC_TEST || cmd_byte == CMD_LOCK_REF) |=> !rsp_valid)
		else $error("put only code answered in get mode");
	get_pulse_a: assert property (get_cmd && cmd_byte == CMD_PULSE_SP |=> rsp_valid)
		else $error("pulse spacing get not answered");
endmodule

// File: tb/tb_touch_setup_command_handler.sv
// Bench joining the register host end and the device end over the link.
// Assumes the host register map of the shared package and one clock.
`timescale 1ns/1ns
module tb_touch_setup_command_handler;
	import touch_setup_pkg::*;
	localparam int TMO = 50;
	localparam logic [7:0] DIN [5] = '{8'h55, 8'h04, 8'hff, 8'h06, 8'h7c};
	localparam logic [7:0] DEX [5] = '{8'h3c, 8'h03, 8'hff, 8'h05, 8'h7b};
	localparam logic [7:0] PIN [4] = '{8'h05, 8'h0b, 8'h01, 8'h0a};
	localparam logic [7:0] PEX [4] = '{8'h05, 8'h05, 8'h05, 8'h0a};
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic        hready;
	logic [31:0] hrdata;
	logic [5:0]  qkey = 6'h00;
	logic [15:0] ref_lvl = 16'h0000;
	logic [15:0] lock_lvl = 16'h0000;
	logic        recal = 1'b0;
	logic [7:0]  pdly, ndly, pulse, pband, nband, dac;
	logic        pen, nen, adj, kerr, perr, nerr, sens, dload, lock;
	int          num_errors = 0;
	int          checked = 0;
	int          nlock = 0;
	int          ndac = 0;

	touch_link_if link ();
	touch_setup_host touch_setup_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(), .hrdata_o(hrdata), .link(link));
	touch_setup_device #(.ARG_TIMEOUT(TMO)) touch_setup_device_inst (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .link(link), .query_key_i(qkey), .ref_level_i(ref_lvl),
		.locked_ref_i(lock_lvl), .key_recalibrated_i(recal), .pos_delay_o(pdly),
		.neg_delay_o(ndly), .pos_recal_en_o(pen), .neg_recal_en_o(nen), .adj_part_o(adj),
		.key_error_o(kerr), .pos_band_err_o(perr), .neg_band_err_o(nerr),
		.pulse_spacing_o(pulse), .pos_band_o(pband), .neg_band_o(nband),
		.sensing_en_o(sens), .dac_value_o(dac), .dac_load_o(dload), .lock_ref_o(lock));
	touch_link_chk #(.ARG_TIMEOUT(TMO)) touch_link_chk_inst (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .cmd_byte(link.cmd_byte), .cmd_valid(link.cmd_valid),
		.put_mode(link.put_mode), .scope_sel(link.scope_sel), .scope_key(link.scope_key),
		.rsp_byte(link.rsp_byte), .rsp_valid(link.rsp_valid));

	// Clock and pulse counters
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (lock === 1'b1) nlock++;
		if (dload === 1'b1) ndac++;
	end

	task automatic conclude();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// One single AHB-Lite transfer, read data taken at the end of the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic ctrl(input logic p, input logic [1:0] s, input logic [5:0] k);
		logic [31:0] d;
		ahb(1'b1, REG_CTRL, {18'h00000, k, 5'h00, s, p}, d);
	endtask

	task automatic send(input logic [7:0] b);
		logic [31:0] d;
		ahb(1'b1, REG_TX, {24'h000000, b}, d);
		step(4);
	endtask

	task automatic put2(input logic [7:0] c, input logic [7:0] a);
		send(c);
		send(a);
	endtask

	// Put with auto return to Get; the echo of the exchange must clear Put mode
	task automatic auto_get_chk();
		logic [31:0] d;
		ahb(1'b1, REG_CTRL, {28'h0000000, 1'b1, SCOPE_ALL, 1'b1}, d);
		put2(CMD_PULSE_SP, 8'h03);
		ahb(1'b0, REG_CTRL, 32'h00000000, d);
		chk("put mode", 8'h00, {7'h00, d[CTRL_PUT_BIT]});
	endtask

	// Reply read; e of zero with f low checks that no reply came
	task automatic rsp(input logic f, input logic [7:0] e);
		logic [31:0] v;
		ahb(1'b0, REG_RX, 32'h00000000, v);
		chk("reply flag", {7'h00, f}, {7'h00, v[RX_NEW_BIT]});
		if (f) chk("reply byte", e, v[7:0]);
	endtask

	initial begin
		step(20000);
		num_errors++;
		conclude();
	end

	initial begin
		step(3);
		reset_i <= 1'b0;
		step(1);
		// Reset values
		chk("pulse", PULSE_RST, pulse);
		chk("adj", 8'h00, {7'h00, adj});
		chk("pos en", 8'h00, {7'h00, pen});
		chk("neg en", 8'h00, {7'h00, nen});
		chk("sens", 8'h01, {7'h00, sens});
		// Delays on one key, rounded down
		ctrl(1'b1, SCOPE_KEY, 6'h05);
		qkey <= 6'h05;
		for (int i = 0; i < 5; i++) begin
			put2(CMD_POS_RECAL, DIN[i]);
			chk("pos delay", DEX[i], pdly);
			put2(CMD_NEG_RECAL, DIN[i]);
			rsp(1'b1, CMD_NEG_RECAL);
			chk("neg delay", DEX[i], ndly);
		end
		chk("pos en", 8'h01, {7'h00, pen});
		qkey <= 6'h06;
		step(2);
		chk("other key", 8'h00, pdly);
		qkey <= 6'h05;
		put2(CMD_POS_RECAL, 8'h00);
		put2(CMD_NEG_RECAL, 8'h00);
		chk("pos en", 8'h00, {7'h00, pen});
		chk("neg en", 8'h00, {7'h00, nen});
		// Pulse spacing, out of range ignored but echoed
		for (int i = 0; i < 4; i++) begin
			put2(CMD_PULSE_SP, PIN[i]);
			rsp(1'b1, CMD_PULSE_SP);
			chk("pulse", PEX[i], pulse);
		end
		put2(CMD_POS_BAND, 8'hc8);
		chk("pos band", POS_BAND_MAX, pband);
		put2(CMD_NEG_BAND, 8'h96);
		chk("neg band", NEG_BAND_MAX, nband);
		put2(CMD_POS_BAND, 8'h02);
		put2(CMD_NEG_BAND, 8'h32);
		// Get mode replies and silences; an argument sent after leaving Put is dropped
		send(CMD_POS_BAND);
		ctrl(1'b0, SCOPE_KEY, 6'h05);
		send(8'h05);
		send(CMD_PULSE_SP);
		rsp(1'b1, 8'h0a);
		chk("pos band", 8'h02, pband);
		send(CMD_NEG_BAND);
		rsp(1'b1, 8'h32);
		send(CMD_DAC_TEST);
		rsp(1'b0, 8'h00);
		send(CMD_LOCK_REF);
		rsp(1'b0, 8'h00);
		// Band flags of the queried key
		lock_lvl <= 16'd100;
		ref_lvl <= 16'd130;
		step(3);
		chk("pos err", 8'h00, {7'h00, perr});
		recal <= 1'b1;
		step(3);
		chk("pos err", 8'h01, {7'h00, perr});
		chk("key err", 8'h01, {7'h00, kerr});
		ref_lvl <= 16'd40;
		step(3);
		chk("neg err", 8'h01, {7'h00, nerr});
		ctrl(1'b1, SCOPE_ALL, 6'h00);
		put2(CMD_NEG_BAND, 8'h00);
		chk("neg err", 8'h00, {7'h00, nerr});
		ref_lvl <= 16'd130;
		put2(CMD_POS_BAND, 8'h00);
		chk("pos err", 8'h00, {7'h00, perr});
		// Suppression on one row
		ctrl(1'b1, SCOPE_ROW, 6'h09);
		put2(CMD_ADJ_SUPP, 8'h01);
		qkey <= 6'h0c;
		step(2);
		chk("adj", 8'h01, {7'h00, adj});
		qkey <= 6'h11;
		step(2);
		chk("adj", 8'h00, {7'h00, adj});
		qkey <= 6'h0c;
		// Lock with and without the null byte
		put2(CMD_LOCK_REF, NULL_BYTE);
		rsp(1'b1, CMD_LOCK_REF);
		put2(CMD_LOCK_REF, 8'h01);
		rsp(1'b0, 8'h00);
		chk("locks", 8'h01, 8'(nlock));
		// Late argument is dropped
		send(CMD_DAC_TEST);
		step(TMO + 10);
		send(8'h33);
		rsp(1'b0, 8'h00);
		chk("sens", 8'h01, {7'h00, sens});
		// DAC test twice, then reset restores sensing
		put2(CMD_DAC_TEST, 8'h5a);
		rsp(1'b1, CMD_DAC_TEST);
		chk("dac", 8'h5a, dac);
		chk("sens", 8'h00, {7'h00, sens});
		chk("adj", 8'h00, {7'h00, adj});
		chk("key err", 8'h01, {7'h00, kerr});
		put2(CMD_DAC_TEST, 8'h5b);
		chk("dac", 8'h5b, dac);
		chk("loads", 8'h02, 8'(ndac));
		auto_get_chk();
		chk("pulse", 8'h03, pulse);
		ctrl(1'b0, SCOPE_KEY, 6'h00);
		reset_i <= 1'b1;
		step(3);
		reset_i <= 1'b0;
		step(2);
		chk("sens", 8'h01, {7'h00, sens});
		chk("dac", DAC_RST, dac);
		conclude();
	end
endmodule
